/* verilog/module_calibration_command_handler.sv */
// Command handler for the plug-in module calibration subsystem
`timescale 1ns/1ps
module module_calibration_command_handler
  import cal_cmd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cmd_valid,               // One-cycle command strobe
  input wire command_type i_cmd,              // Command contents
  input wire logic i_module_present,          // Pin: supported module in first slot
  input wire cal_date_type i_rtc_date,        // Real-time clock date, same domain
  input wire logic [15:0] i_second_tally,     // Second slot module stored count
  input wire cal_date_type i_second_date,     // Second slot module stored date
  output logic o_answer_valid,                // One-cycle answer strobe
  output answer_type o_answer,                // Query answer
  output logic o_accept,                      // One-cycle: command carried out
  output logic o_error,                       // One-cycle: command refused
  output logic [15:0] o_dac_value,            // Current source DAC setting
  output logic o_nvm_write,                   // One-cycle save strobe
  output nvm_record_type o_nvm_data           // Record to save
);

  ////////////////////////////////////////////////////////////////////////////
  // Password check

  // Character legal inside the password: letter or digit
  function automatic logic is_alnum(input logic [7:0] c);
    is_alnum = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5a) ||
               (c >= 8'h61 && c <= 8'h7a);
  endfunction

  // Quoted string: opening quote, 0..8 alphanumerics, closing quote, zeros
  function automatic logic [64:0] parse_pw(input logic [79:0] t);
    logic ok;
    logic done;
    logic [63:0] body;
    logic [7:0] c;
    ok = (t[79:72] == QUOTE_CHAR);
    done = 1'b0;
    body = 64'h0;
    for (int i = 1; i <= PW_CHARS + 1; i++) begin
      c = t[79 - 8 * i -: 8];
      if (!done) begin
        if (c == QUOTE_CHAR) begin
          done = 1'b1;
        end else if (i <= PW_CHARS && is_alnum(c)) begin
          body[71 - 8 * i -: 8] = c;
        end else begin
          ok = 1'b0;
        end
      end else if (c != 8'h00) begin
        ok = 1'b0;                            // Trailing junk after closing quote
      end
    end
    parse_pw = {ok & done, body};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Presence pin synchroniser

  logic present_meta_reg;                     // First stage, read only by second
  logic present_reg;                          // Safe to use

  // Two flops for the slot presence pin
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      present_meta_reg <= 1'b0;
      present_reg <= 1'b0;
    end else begin
      present_meta_reg <= i_module_present;
      present_reg <= present_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers

  cal_state_type state_reg;
  cal_state_type state_next;
  logic low_done_reg;                         // Low point step executed
  logic low_done_next;
  logic high_done_reg;                        // High point step executed
  logic high_done_next;
  logic [15:0] tally_reg;                     // First slot count
  logic [15:0] tally_next;
  cal_date_type date_reg;                     // First slot calibration date
  cal_date_type date_next;
  logic [31:0] low_rd_reg;
  logic [31:0] low_rd_next;
  logic [31:0] high_rd_reg;
  logic [31:0] high_rd_next;
  logic [15:0] dac_next;
  logic accept_next;
  logic error_next;
  logic answer_next;
  logic nvm_next;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  wire logic [64:0] pw_parsed = parse_pw(i_cmd.pw_text);
  wire logic pw_ok = pw_parsed[64] && (pw_parsed[63:0] == DEFAULT_PASSWORD);
  wire logic first_slot_path = (i_cmd.slot == SLOT_FIRST);
  wire logic second_slot_path = (i_cmd.slot == SLOT_SECOND);
  wire logic is_query = (i_cmd.op == cmd_count_q) || (i_cmd.op == cmd_date_q) ||
                        (i_cmd.op == cmd_lock_q);
  wire logic locked = (state_reg == st_locked);
  // Second slot takes only count and date queries
  wire logic slot_ok = first_slot_path ||
                       (second_slot_path && (i_cmd.op == cmd_count_q || i_cmd.op == cmd_date_q));
  wire logic in_session = (state_reg == st_started) || (state_reg == st_stepping);

  ////////////////////////////////////////////////////////////////////////////
  // Command execution

  // One command per strobe; any refusal leaves all state untouched
  always_comb begin
    state_next = state_reg;
    low_done_next = low_done_reg;
    high_done_next = high_done_reg;
    tally_next = tally_reg;
    date_next = date_reg;
    low_rd_next = low_rd_reg;
    high_rd_next = high_rd_reg;
    dac_next = o_dac_value;
    accept_next = 1'b0;
    error_next = 1'b0;
    answer_next = 1'b0;
    nvm_next = 1'b0;
    if (i_cmd_valid) begin
      if (i_cmd.op != cmd_code && !slot_ok) begin
        error_next = 1'b1;
      end else if (locked && !is_query && i_cmd.op != cmd_code) begin
        error_next = 1'b1;
      end else if (!is_query && i_cmd.op != cmd_code && !present_reg) begin
        error_next = 1'b1;                    // No module to calibrate
      end else begin
        accept_next = 1'b1;
        unique case (i_cmd.op)
          cmd_code: begin
            if (pw_ok) begin
              // Resending inside a session keeps the session
              if (locked) begin
                state_next = st_unlocked;
              end
            end else begin
              accept_next = 1'b0;
              error_next = 1'b1;
            end
          end
          cmd_init: begin
            state_next = st_started;
            low_done_next = 1'b0;
            high_done_next = 1'b0;
          end
          cmd_count_q, cmd_date_q, cmd_lock_q: begin
            answer_next = 1'b1;
          end
          cmd_tally_clr: begin
            tally_next = TALLY_RESET;
          end
          cmd_lock: begin
            state_next = st_locked;
            dac_next = DAC_OFF;
            low_done_next = 1'b0;
            high_done_next = 1'b0;
          end
          cmd_low_step, cmd_high_step: begin
            if (in_session) begin
              state_next = st_stepping;
              if (i_cmd.op == cmd_low_step) begin
                dac_next = DAC_LOW_POINT;
                low_done_next = 1'b1;
              end else begin
                dac_next = DAC_HIGH_POINT;
                high_done_next = 1'b1;
              end
            end else begin
              accept_next = 1'b0;
              error_next = 1'b1;              // Step before initiate
            end
          end
          cmd_readings: begin
            if (state_reg == st_stepping && low_done_reg && high_done_reg) begin
              low_rd_next = i_cmd.low_reading;  // First reading is low
              high_rd_next = i_cmd.high_reading;
              tally_next = tally_reg + 16'h0001; // Calibration completed
              date_next = i_rtc_date;
              dac_next = DAC_OFF;
              state_next = st_started;
              low_done_next = 1'b0;
              high_done_next = 1'b0;
            end else begin
              accept_next = 1'b0;
              error_next = 1'b1;
            end
          end
          cmd_save: begin
            if (in_session) begin
              nvm_next = 1'b1;
            end else begin
              accept_next = 1'b0;
              error_next = 1'b1;
            end
          end
          default: begin
            accept_next = 1'b0;               // Undefined opcode code
            error_next = 1'b1;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer selection

  wire logic [15:0] count_sel = second_slot_path ? i_second_tally : tally_reg;
  wire cal_date_type date_sel = second_slot_path ? i_second_date : date_reg;
  wire logic [3:0] lock_sel = locked ? LOCK_Q_LOCKED : LOCK_Q_UNLOCKED;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Session state and calibration data
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= st_locked;
      low_done_reg <= 1'b0;
      high_done_reg <= 1'b0;
      tally_reg <= TALLY_RESET;
      date_reg <= '0;
      low_rd_reg <= 32'h0;
      high_rd_reg <= 32'h0;
      o_dac_value <= DAC_OFF;
    end else begin
      state_reg <= state_next;
      low_done_reg <= low_done_next;
      high_done_reg <= high_done_next;
      tally_reg <= tally_next;
      date_reg <= date_next;
      low_rd_reg <= low_rd_next;
      high_rd_reg <= high_rd_next;
      o_dac_value <= dac_next;
    end
  end

  // Strobes and answer data, all registered
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_accept <= 1'b0;
      o_error <= 1'b0;
      o_answer_valid <= 1'b0;
      o_answer <= '0;
      o_nvm_write <= 1'b0;
      o_nvm_data <= '0;
    end else begin
      o_accept <= accept_next;
      o_error <= error_next;
      o_answer_valid <= answer_next;
      o_nvm_write <= nvm_next;
      if (answer_next) begin
        o_answer <= '{count: count_sel, date: date_sel, lock_state: lock_sel};
      end
      if (nvm_next) begin
        o_nvm_data <= '{low_reading: low_rd_reg, high_reading: high_rd_reg,
                        tally: tally_reg, date: date_reg};
      end
    end
  end

endmodule

/* verilog/cal_cmd_pkg.sv */
// Shared constants and types for the module calibration command handler
package cal_cmd_pkg;

  // Command opcodes, already decoded from the text stream upstream
  typedef enum logic [3:0] {
    cmd_code       = 4'h0,
    cmd_init       = 4'h1,
    cmd_count_q    = 4'h2,
    cmd_tally_clr  = 4'h3,
    cmd_date_q     = 4'h4,
    cmd_save       = 4'h5,
    cmd_lock       = 4'h6,
    cmd_lock_q     = 4'h7,
    cmd_low_step   = 4'h8,
    cmd_high_step  = 4'h9,
    cmd_readings   = 4'ha
  } opcode_type;

  // Calibration session states, one-hot
  typedef enum logic [3:0] {
    st_locked   = 4'b0001,
    st_unlocked = 4'b0010,
    st_started  = 4'b0100,
    st_stepping = 4'b1000
  } cal_state_type;

  localparam int PW_CHARS = 8;
  localparam logic [7:0] QUOTE_CHAR = 8'h27;
  // Arbitrary factory password value, "CALPASS1"
  localparam logic [63:0] DEFAULT_PASSWORD = 64'h43414c5041535331;

  // Current source DAC settings for the two calibration points
  localparam logic [15:0] DAC_LOW_POINT = 16'h0419;
  localparam logic [15:0] DAC_HIGH_POINT = 16'hcccd;
  localparam logic [15:0] DAC_OFF = 16'h0000;

  localparam logic [1:0] SLOT_FIRST = 2'h1;
  localparam logic [1:0] SLOT_SECOND = 2'h2;

  localparam logic [15:0] TALLY_RESET = 16'h0000;
  localparam logic [3:0] LOCK_Q_LOCKED = 4'h0;
  localparam logic [3:0] LOCK_Q_UNLOCKED = 4'h1;

  // Calendar date
  typedef struct packed {
    logic [15:0] year;
    logic [7:0] month;
    logic [7:0] day;
  } cal_date_type;

  // One decoded command from the parser
  typedef struct packed {
    opcode_type op;
    logic [1:0] slot;
    logic [79:0] pw_text;     // Quote, up to eight chars, quote; left aligned, zero fill
    logic [31:0] low_reading;
    logic [31:0] high_reading;
  } command_type;

  // Answer to a query
  typedef struct packed {
    logic [15:0] count;
    cal_date_type date;
    logic [3:0] lock_state;
  } answer_type;

  // Constants written to non-volatile memory
  typedef struct packed {
    logic [31:0] low_reading;
    logic [31:0] high_reading;
    logic [15:0] tally;
    cal_date_type date;
  } nvm_record_type;

endpackage

/* sim/cal_host_model.sv */
// Host model: puts one decoded command per request on the handler's command port
`timescale 1ns/1ps
module cal_host_model
  import cal_cmd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_send,         // Request from the bench
  input wire command_type i_next,  // Command to present
  output logic o_cmd_valid,        // One-cycle strobe
  output command_type o_cmd        // Command contents
);
  // One strobe per request; idle contents scrambled so nothing stale looks usable
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cmd_valid <= 1'b0;
      o_cmd <= '0;
    end else begin
      o_cmd_valid <= i_send;
      o_cmd <= i_send ? i_next : ~o_cmd;
    end
  end
endmodule

/* sim/cal_cmd_checker.sv */
// Port-level assertions for the calibration command handler
`timescale 1ns/1ps
module cal_cmd_checker
  import cal_cmd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input wire command_type i_cmd,
  input wire logic i_module_present,
  input wire cal_date_type i_rtc_date,
  input wire logic [15:0] i_second_tally,
  input wire cal_date_type i_second_date,
  input wire logic o_answer_valid,
  input wire answer_type o_answer,
  input wire logic o_accept,
  input wire logic o_error,
  input wire logic [15:0] o_dac_value,
  input wire logic o_nvm_write,
  input wire nvm_record_type o_nvm_data
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Commands allowed anywhere, even locked or with no module
  wire logic free_cmd = i_cmd.op inside {cmd_code, cmd_count_q, cmd_date_q, cmd_lock_q};
  ////////////////////////////////////////////////////////////////////////////
  // Accepted step and lock commands
  sequence s_low_done;
    i_cmd_valid && i_cmd.op == cmd_low_step ##1 o_accept;
  endsequence
  sequence s_high_done;
    i_cmd_valid && i_cmd.op == cmd_high_step ##1 o_accept;
  endsequence
  sequence s_lock_done;
    i_cmd_valid && i_cmd.op == cmd_lock ##1 o_accept;
  endsequence
  a_single_answer: assert property (i_cmd_valid |=> o_accept != o_error)
    else $error("command not answered exactly once");
  a_quiet_idle: assert property (!i_cmd_valid |=> !o_accept && !o_error && !o_nvm_write)
    else $error("strobe without a command");
  a_low_point: assert property (s_low_done |-> o_dac_value == DAC_LOW_POINT)
    else $error("low step did not set low point");
  a_high_point: assert property (s_high_done |-> o_dac_value == DAC_HIGH_POINT)
    else $error("high step did not set high point");
  a_lock_reads0: assert property (s_lock_done ##1 !i_cmd_valid ##1 i_cmd_valid && i_cmd.op == cmd_lock_q
    |=> o_answer.lock_state == LOCK_Q_LOCKED && o_dac_value == DAC_OFF)
    else $error("lock not reported");
  a_second_slot: assert property (i_cmd_valid && i_cmd.slot != SLOT_FIRST && i_cmd.op != cmd_code
    && !(i_cmd.op inside {cmd_count_q, cmd_date_q}) |=> o_error)
    else $error("second slot command not refused");
  a_second_tally: assert property (i_cmd_valid && i_cmd.slot == SLOT_SECOND && i_cmd.op == cmd_count_q
    |=> o_answer_valid && o_answer.count == $past(i_second_tally))
    else $error("second slot count wrong");
  a_absent_refuse: assert property (!i_module_present [*4] ##0 i_cmd_valid && !free_cmd |=> o_error)
    else $error("command taken without module");
  a_save_strobe: assert property (o_nvm_write |-> $past(i_cmd_valid) && $past(i_cmd.op) == cmd_save)
    else $error("save strobe without save");
  a_refuse_holds: assert property (o_error |-> $stable(o_dac_value) && !o_answer_valid)
    else $error("refused command changed state");
endmodule
bind module_calibration_command_handler cal_cmd_checker chk_u (.i_clk(i_clk), .i_rst(i_rst),
  .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_module_present(i_module_present), .i_rtc_date(i_rtc_date),
  .i_second_tally(i_second_tally), .i_second_date(i_second_date), .o_answer_valid(o_answer_valid),
  .o_answer(o_answer), .o_accept(o_accept), .o_error(o_error), .o_dac_value(o_dac_value),
  .o_nvm_write(o_nvm_write), .o_nvm_data(o_nvm_data));

/* sim/tb_top.sv */
// Self-checking bench for the calibration command handler
`timescale 1ns/1ps
module tb_top;
  import cal_cmd_pkg::*;
  localparam logic [79:0] PW_GOOD = {QUOTE_CHAR, DEFAULT_PASSWORD, QUOTE_CHAR};
  localparam logic [79:0] PW_BAD = {QUOTE_CHAR, DEFAULT_PASSWORD ^ 64'h1, QUOTE_CHAR};
  localparam logic [31:0] RD_LOW = 32'h000003e9;
  localparam logic [31:0] RD_HIGH = 32'h0000c351;
  localparam cal_date_type RTC = '{16'h07e8, 8'h05, 8'h11};
  localparam cal_date_type SEC_DATE = '{16'h07e5, 8'h0a, 8'h02};
  localparam logic [15:0] SEC_TALLY = 16'h002a;
  localparam logic [1:0] S1 = SLOT_FIRST;
  localparam logic [1:0] S2 = SLOT_SECOND;
  // One table row: command, expected verdict, DAC and answer field
  typedef struct packed {
    opcode_type op;
    logic [1:0] slot;
    logic ok;
    logic [15:0] dac;
    logic [2:0] chk;
    logic [15:0] val;
  } row_type;
  localparam row_type ROWS [27] = '{
    '{cmd_lock_q, S1, 1'b1, DAC_OFF, 3'h1, 16'h0}, '{cmd_init, S1, 1'b0, DAC_OFF, 3'h0, 16'h0},
    '{cmd_code, S1, 1'b0, DAC_OFF, 3'h0, 16'h0}, '{cmd_code, S1, 1'b1, DAC_OFF, 3'h0, 16'h0},
    '{cmd_lock_q, S1, 1'b1, DAC_OFF, 3'h1, 16'h1}, '{cmd_low_step, S1, 1'b0, DAC_OFF, 3'h0, 16'h0},
    '{cmd_init, S1, 1'b1, DAC_OFF, 3'h0, 16'h0}, '{cmd_readings, S1, 1'b0, DAC_OFF, 3'h0, 16'h0},
    '{cmd_low_step, S1, 1'b1, DAC_LOW_POINT, 3'h0, 16'h0},
    '{cmd_readings, S1, 1'b0, DAC_LOW_POINT, 3'h0, 16'h0},
    '{cmd_high_step, S1, 1'b1, DAC_HIGH_POINT, 3'h0, 16'h0},
    '{cmd_readings, S1, 1'b1, DAC_OFF, 3'h0, 16'h0}, '{cmd_readings, S1, 1'b0, DAC_OFF, 3'h0, 16'h0},
    '{cmd_count_q, S1, 1'b1, DAC_OFF, 3'h2, 16'h1}, '{cmd_date_q, S1, 1'b1, DAC_OFF, 3'h3, 16'h0},
    '{cmd_save, S1, 1'b1, DAC_OFF, 3'h4, 16'h0}, '{cmd_init, S2, 1'b0, DAC_OFF, 3'h0, 16'h0},
    '{cmd_count_q, S2, 1'b1, DAC_OFF, 3'h2, SEC_TALLY}, '{cmd_date_q, S2, 1'b1, DAC_OFF, 3'h5, 16'h0},
    '{cmd_tally_clr, S1, 1'b1, DAC_OFF, 3'h0, 16'h0}, '{cmd_count_q, S1, 1'b1, DAC_OFF, 3'h2, 16'h0},
    '{cmd_code, S1, 1'b1, DAC_OFF, 3'h0, 16'h0}, '{cmd_low_step, S1, 1'b1, DAC_LOW_POINT, 3'h0, 16'h0},
    '{cmd_lock, S1, 1'b1, DAC_OFF, 3'h0, 16'h0}, '{cmd_lock_q, S1, 1'b1, DAC_OFF, 3'h1, 16'h0},
    '{cmd_high_step, S1, 1'b0, DAC_OFF, 3'h0, 16'h0}, '{cmd_tally_clr, S1, 1'b0, DAC_OFF, 3'h0, 16'h0}};
  logic i_clk, i_rst, send, present, cmd_valid, answer_valid, accept, error, nvm_write;
  command_type nxt, cmd;
  answer_type answer;
  logic [15:0] dac_value;
  logic [79:0] pw_wrong;           // Text sent by a refused password row
  nvm_record_type nvm_data;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  cal_host_model host_u (.i_clk(i_clk), .i_rst(i_rst), .i_send(send), .i_next(nxt),
    .o_cmd_valid(cmd_valid), .o_cmd(cmd));
  module_calibration_command_handler dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(cmd_valid),
    .i_cmd(cmd), .i_module_present(present), .i_rtc_date(RTC), .i_second_tally(SEC_TALLY),
    .i_second_date(SEC_DATE), .o_answer_valid(answer_valid), .o_answer(answer), .o_accept(accept),
    .o_error(error), .o_dac_value(dac_value), .o_nvm_write(nvm_write), .o_nvm_data(nvm_data));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [111:0] exp, input logic [111:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Send one command and judge the verdict; a refused password row sends the wrong code
  task automatic run(input opcode_type op, input logic [1:0] slot, input logic ok);
    @(posedge i_clk);
    send <= 1'b1;
    nxt <= '{op, slot, (op == cmd_code && !ok) ? pw_wrong : PW_GOOD, RD_LOW, RD_HIGH};
    @(posedge i_clk);
    send <= 1'b0;
    @(posedge i_clk);
    #1;
    check("verdict", 112'({ok, !ok}), 112'({accept, error}));
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // Hang guard, far above the roughly 130 cycles the run needs
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    i_rst = 1'b1;
    send = 1'b0;
    nxt = '0;
    pw_wrong = PW_BAD;
    present = 1'b1;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 27; i++) begin
      run(ROWS[i].op, ROWS[i].slot, ROWS[i].ok);
      check("dac", 112'(ROWS[i].dac), 112'(dac_value));
      check("strobes", 112'({(ROWS[i].chk inside {3'h1, 3'h2, 3'h3, 3'h5}), ROWS[i].chk == 3'h4}),
        112'({answer_valid, nvm_write}));
      case (ROWS[i].chk)
        3'h1: check("lock", 112'(ROWS[i].val), 112'(answer.lock_state));
        3'h2: check("count", 112'(ROWS[i].val), 112'(answer.count));
        3'h3: check("date", 112'(RTC), 112'(answer.date));
        3'h4: check("nvm", {RD_LOW, RD_HIGH, 16'h0001, RTC}, nvm_data);
        3'h5: check("date2", 112'(SEC_DATE), 112'(answer.date));
        default: ;
      endcase
      $display("row %0d done", i);
    end
    // Reset in mid-session drops the source and relocks
    run(cmd_code, S1, 1'b1);
    run(cmd_init, S1, 1'b1);
    run(cmd_low_step, S1, 1'b1);
    @(posedge i_clk);
    i_rst <= 1'b1;
    @(posedge i_clk);
    #1;
    check("dac reset", 112'(DAC_OFF), 112'(dac_value));
    @(posedge i_clk);
    i_rst <= 1'b0;
    run(cmd_lock_q, S1, 1'b1);
    check("lock reset", 112'(LOCK_Q_LOCKED), 112'(answer.lock_state));
    $display("reset test done");
    // Save before initiate, an undefined opcode and a stray slot are all refused
    run(cmd_code, S1, 1'b1);
    run(cmd_save, S1, 1'b0);
    run(opcode_type'(4'hb), S1, 1'b0);
    run(cmd_count_q, 2'h3, 1'b0);
    $display("odd command test done");
    // Module pulled: password still taken, calibration refused
    @(posedge i_clk);
    present <= 1'b0;
    run(cmd_code, S1, 1'b1);
    run(cmd_init, S1, 1'b0);
    $display("absent module test done");
    // Right characters but no quotes, then nine characters with no closing quote
    pw_wrong = {8'h00, DEFAULT_PASSWORD, 8'h00};
    run(cmd_code, S1, 1'b0);
    pw_wrong = {QUOTE_CHAR, DEFAULT_PASSWORD, 8'h31};
    run(cmd_code, S1, 1'b0);
    $display("malformed password test done");
    final_report();
  end
endmodule
